// ### logic/sbc_pkg.sv
package sbc_pkg;
	// ----------------------------------------
	// organisation
	// ----------------------------------------
	localparam int ROW_W = 12;
	localparam int COL_W = 8;
	localparam int BANKS = 4;
	localparam int DQ_W = 16;
	localparam int LANES = 2;
	localparam int AP_BIT = 10;
	localparam int BURST_LEN = 4;
	// ----------------------------------------
	// commands on {cs_n, ras_n, cas_n, we_n}
	// ----------------------------------------
	typedef enum logic [3:0] {
		CMD_LMR = 4'h0,
		CMD_REF = 4'h1,
		CMD_PRE = 4'h2,
		CMD_ACT = 4'h3,
		CMD_WRITE = 4'h4,
		CMD_READ = 4'h5,
		CMD_BST = 4'h6,
		CMD_NOP = 4'h7
	} sbc_cmd_t;
	typedef enum logic [1:0] {
		MODE_IDLE = 2'h0,
		MODE_READ = 2'h1,
		MODE_WRITE = 2'h3,
		MODE_SREF = 2'h2
	} sbc_mode_t;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_REFCNT = 8'h08;
	localparam int CTRL_FULL_PAGE = 0;
	localparam int STAT_OPEN_LSB = 0;
	localparam int STAT_SREF = 4;
	localparam int STAT_ILLEGAL = 5;
	localparam logic CTRL_FULL_PAGE_RST = 1'b0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 8;
	localparam int REF_INTERVAL_NS = 15625;
	localparam int REF_INTERVAL_CYC = REF_INTERVAL_NS / CLK_PERIOD_NS;
endpackage

// ### logic/sbc_bank_if.sv
`timescale 1ns/1ns
interface sbc_bank_if;
	logic act;
	logic [1:0] bank;
	logic [sbc_pkg::ROW_W-1:0] row;
	logic [sbc_pkg::BANKS-1:0] close;
	logic [sbc_pkg::BANKS-1:0] open;
	logic [sbc_pkg::BANKS-1:0][sbc_pkg::ROW_W-1:0] open_row;
	modport ctl (output act, bank, row, close, input open, open_row);
	modport trk (input act, bank, row, close, output open, open_row);
endinterface

// ### logic/sbc_banks.sv
`timescale 1ns/1ns
module sbc_banks (
	input wire logic clk_sys,
	input wire logic reset,
	sbc_bank_if.trk bif
);
	// ----------------------------------------
	// per-bank open flag and open row
	// ----------------------------------------
	logic [sbc_pkg::BANKS-1:0] open_ff;
	logic [sbc_pkg::BANKS-1:0] nxt_open;
	logic [sbc_pkg::BANKS-1:0][sbc_pkg::ROW_W-1:0] row_ff;
	logic [sbc_pkg::BANKS-1:0][sbc_pkg::ROW_W-1:0] nxt_row;

	genvar b;
	generate
		for (b = 0; b < sbc_pkg::BANKS; b++)
		begin : g_bank
			always_comb
			begin
				nxt_open[b] = open_ff[b];
				nxt_row[b] = row_ff[b];
				if (bif.close[b])
				begin
					nxt_open[b] = 1'b0;
				end
				else if (bif.act && bif.bank == 2'(b))
				begin
					nxt_open[b] = 1'b1;
					nxt_row[b] = bif.row;
				end
			end
			always_ff @(posedge clk_sys)
			begin
				if (reset)
				begin
					open_ff[b] <= 1'b0;
					row_ff[b] <= '0;
				end
				else
				begin
					open_ff[b] <= nxt_open[b];
					row_ff[b] <= nxt_row[b];
				end
			end
			assign bif.open[b] = open_ff[b];
			assign bif.open_row[b] = row_ff[b];

			a_row_held_open: assert property (@(posedge clk_sys)
				disable iff (reset)
				(open_ff[b] && !bif.close[b]) |=> (row_ff[b] == $past(row_ff[b])))
				else $error("open row changed without precharge");
		end
	endgenerate
endmodule

// ### logic/sbc_top.sv
`timescale 1ns/1ns
module sbc_top #(
	parameter int MEM_ROW_BITS = 1,
	parameter int MEM_COL_BITS = 3
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic bank_select_bit_zero,
	input wire logic bank_select_bit_one,
	input wire logic [11:0] addr,
	input wire logic [1:0] dqm,
	input wire logic [15:0] dq_in,
	output logic [15:0] dq_out,
	output logic [15:0] dq_oe,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	localparam int IDX_W = 2 + MEM_ROW_BITS + MEM_COL_BITS;
	localparam int WORDS = 1 << IDX_W;

	sbc_bank_if bif ();
	sbc_banks u_banks (.clk_sys(clk_sys), .reset(reset), .bif(bif.trk));

	// ----------------------------------------
	// command decode
	// ----------------------------------------
	logic [3:0] cmd;
	logic [1:0] bsel;
	logic [sbc_pkg::COL_W-1:0] col_in;
	logic ap_in;
	logic in_sref, live, sel_open;
	logic is_act, is_rd, is_wr, is_bst, is_pre, is_ref, is_sre;
	logic ill_act, ill_rw, ill_ref;
	sbc_pkg::sbc_mode_t mode_ff, nxt_mode;

	assign cmd = {cs_n, ras_n, cas_n, we_n};
	assign bsel = {bank_select_bit_one, bank_select_bit_zero};
	assign col_in = addr[sbc_pkg::COL_W-1:0];
	assign ap_in = addr[sbc_pkg::AP_BIT];
	assign in_sref = (mode_ff == sbc_pkg::MODE_SREF);
	// self refresh: only cke is looked at
	assign live = cke && !in_sref;
	assign sel_open = bif.open[bsel];
	assign is_act = live && cmd == sbc_pkg::CMD_ACT;
	assign is_rd = live && cmd == sbc_pkg::CMD_READ;
	assign is_wr = live && cmd == sbc_pkg::CMD_WRITE;
	assign is_bst = live && cmd == sbc_pkg::CMD_BST;
	assign is_pre = live && cmd == sbc_pkg::CMD_PRE;
	assign is_ref = live && cmd == sbc_pkg::CMD_REF;
	assign is_sre = !cke && !in_sref && cmd == sbc_pkg::CMD_REF;
	// illegal commands are dropped, not executed
	assign ill_act = is_act && sel_open;
	assign ill_rw = (is_rd || is_wr) && !sel_open;
	assign ill_ref = (is_ref || is_sre) && (|bif.open);

	// ----------------------------------------
	// burst engine and self refresh
	// ----------------------------------------
	logic [1:0] bank_ff, nxt_bank;
	logic [sbc_pkg::COL_W-1:0] col_ff, nxt_col;
	logic [sbc_pkg::COL_W:0] left_ff, nxt_left;
	logic ap_ff, nxt_ap;
	logic [11:0] refcnt_ff, nxt_refcnt;
	logic [15:0] srtmr_ff, nxt_srtmr;
	logic full_page_ff;
	logic acc_v, acc_wr, acc_last, acc_ap;
	logic [1:0] acc_bank;
	logic [sbc_pkg::COL_W-1:0] acc_col;
	logic [sbc_pkg::BANKS-1:0] close;

	always_comb
	begin
		acc_v = 1'b0;
		acc_wr = 1'b0;
		acc_bank = bank_ff;
		acc_col = col_ff;
		acc_ap = ap_ff;
		nxt_mode = mode_ff;
		nxt_bank = bank_ff;
		nxt_col = col_ff;
		nxt_left = left_ff;
		nxt_ap = ap_ff;
		nxt_refcnt = refcnt_ff;
		nxt_srtmr = srtmr_ff;
		if ((is_rd || is_wr) && !ill_rw)
		begin
			acc_v = 1'b1;
			acc_wr = is_wr;
			acc_bank = bsel;
			acc_col = col_in;
			acc_ap = ap_in && !full_page_ff;
			nxt_mode = is_wr ? sbc_pkg::MODE_WRITE : sbc_pkg::MODE_READ;
			nxt_left = (sbc_pkg::COL_W+1)'(sbc_pkg::BURST_LEN - 1);
		end
		else if (mode_ff == sbc_pkg::MODE_READ
			|| mode_ff == sbc_pkg::MODE_WRITE)
		begin
			// terminate or precharge of this bank ends the burst here
			if (!is_bst && !(is_pre && (ap_in || bsel == bank_ff)))
			begin
				acc_v = 1'b1;
				acc_wr = (mode_ff == sbc_pkg::MODE_WRITE);
				nxt_left = left_ff - 1'b1;
			end
			else
			begin
				nxt_mode = sbc_pkg::MODE_IDLE;
			end
		end
		acc_last = acc_v && nxt_left == '0 && !full_page_ff;
		if (acc_v)
		begin
			nxt_bank = acc_bank;
			nxt_col = acc_col + 1'b1; // full page wraps within row
			nxt_ap = acc_ap;
		end
		if (acc_last)
		begin
			nxt_mode = sbc_pkg::MODE_IDLE;
		end
		if (is_ref && !ill_ref)
		begin
			nxt_refcnt = refcnt_ff + 1'b1;
		end
		if (is_sre && !ill_ref)
		begin
			nxt_mode = sbc_pkg::MODE_SREF;
			nxt_srtmr = '0;
		end
		else if (in_sref)
		begin
			nxt_srtmr = srtmr_ff + 1'b1;
			if (srtmr_ff == 16'(sbc_pkg::REF_INTERVAL_CYC - 1))
			begin
				nxt_srtmr = '0;
				nxt_refcnt = refcnt_ff + 1'b1;
			end
			if (cke)
			begin
				nxt_mode = sbc_pkg::MODE_IDLE;
			end
		end
		close = '0;
		if (is_pre)
		begin
			close = ap_in ? '1 : 4'(1 << bsel);
		end
		if (acc_last && acc_ap)
		begin
			close[acc_bank] = 1'b1;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			mode_ff <= sbc_pkg::MODE_IDLE;
			bank_ff <= '0;
			col_ff <= '0;
			left_ff <= '0;
			ap_ff <= 1'b0;
			refcnt_ff <= '0;
			srtmr_ff <= '0;
		end
		else
		begin
			mode_ff <= nxt_mode;
			bank_ff <= nxt_bank;
			col_ff <= nxt_col;
			left_ff <= nxt_left;
			ap_ff <= nxt_ap;
			refcnt_ff <= nxt_refcnt;
			srtmr_ff <= nxt_srtmr;
		end
	end

	assign bif.act = is_act && !ill_act;
	assign bif.bank = bsel;
	assign bif.row = addr;
	assign bif.close = close;

	// ----------------------------------------
	// array and read pipeline
	// ----------------------------------------
	// small array: only low row and column bits address it, so it aliases
	logic [IDX_W-1:0] idx;
	logic [15:0] mem_ff [WORDS];
	logic [15:0] nxt_mem [WORDS];
	logic rd1_v_ff, nxt_rd1_v;
	logic [15:0] rd1_d_ff, nxt_rd1_d;
	logic [1:0] dqm1_ff;
	logic [15:0] dq_out_ff, dq_oe_ff, nxt_oe;
	logic [7:0] wr_lo;

	assign idx = {acc_bank, bif.open_row[acc_bank][MEM_ROW_BITS-1:0],
		acc_col[MEM_COL_BITS-1:0]};
	assign wr_lo = dq_in[7:0];

	always_comb
	begin
		nxt_mem = mem_ff;
		nxt_rd1_v = acc_v && !acc_wr;
		nxt_rd1_d = mem_ff[idx];
		for (int l = 0; l < sbc_pkg::LANES; l++)
		begin
			if (acc_v && acc_wr && !dqm[l])
			begin
				nxt_mem[idx][l*8 +: 8] = dq_in[l*8 +: 8];
			end
			// mask taken one edge before feeds this stage: two-clock latency
			nxt_oe[l*8 +: 8] = {8{rd1_v_ff && !dqm1_ff[l] && !is_wr}};
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			rd1_v_ff <= 1'b0;
			rd1_d_ff <= '0;
			dqm1_ff <= '0;
			dq_out_ff <= '0;
			dq_oe_ff <= '0;
		end
		else
		begin
			rd1_v_ff <= nxt_rd1_v;
			rd1_d_ff <= nxt_rd1_d;
			dqm1_ff <= dqm;
			dq_out_ff <= rd1_d_ff;
			dq_oe_ff <= nxt_oe;
		end
	end

	// array contents are not reset: a real array powers up random
	always_ff @(posedge clk_sys)
	begin
		mem_ff <= nxt_mem;
	end

	assign dq_out = dq_out_ff;
	assign dq_oe = dq_oe_ff;

	// ----------------------------------------
	// register slave
	// ----------------------------------------
	logic aw_hold_ff, nxt_aw_hold, w_hold_ff, nxt_w_hold;
	logic [7:0] awaddr_ff, nxt_awaddr;
	logic [31:0] wdata_ff, nxt_wdata;
	logic wstrb0_ff, nxt_wstrb0;
	logic bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
	logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
	logic [31:0] rdata_ff, nxt_rdata, status;
	logic illegal_ff, nxt_illegal, nxt_full_page;

	assign status = {26'h0, illegal_ff, in_sref, bif.open};

	always_comb
	begin
		nxt_aw_hold = aw_hold_ff;
		nxt_w_hold = w_hold_ff;
		nxt_awaddr = awaddr_ff;
		nxt_wdata = wdata_ff;
		nxt_wstrb0 = wstrb0_ff;
		nxt_bvalid = bvalid_ff && !s_axi_bready;
		nxt_bresp = bresp_ff;
		nxt_rvalid = rvalid_ff && !s_axi_rready;
		nxt_rresp = rresp_ff;
		nxt_rdata = rdata_ff;
		nxt_full_page = full_page_ff;
		nxt_illegal = illegal_ff;
		if (s_axi_awvalid && s_axi_awready)
		begin
			nxt_aw_hold = 1'b1;
			nxt_awaddr = s_axi_awaddr[7:0];
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			nxt_w_hold = 1'b1;
			nxt_wdata = s_axi_wdata;
			nxt_wstrb0 = s_axi_wstrb[0];
		end
		if (aw_hold_ff && w_hold_ff && !bvalid_ff)
		begin
			nxt_aw_hold = 1'b0;
			nxt_w_hold = 1'b0;
			nxt_bvalid = 1'b1;
			nxt_bresp = sbc_pkg::RESP_OKAY;
			if (awaddr_ff == sbc_pkg::OFS_CTRL && wstrb0_ff)
			begin
				nxt_full_page = wdata_ff[sbc_pkg::CTRL_FULL_PAGE];
			end
			else if (awaddr_ff == sbc_pkg::OFS_STATUS && wstrb0_ff
				&& wdata_ff[sbc_pkg::STAT_ILLEGAL])
			begin
				nxt_illegal = 1'b0;
			end
			else if (awaddr_ff != sbc_pkg::OFS_CTRL
				&& awaddr_ff != sbc_pkg::OFS_STATUS)
			begin
				nxt_bresp = sbc_pkg::RESP_SLVERR;
			end
		end
		// a new illegal command beats a clear in the same cycle
		if (ill_act || ill_rw || ill_ref)
		begin
			nxt_illegal = 1'b1;
		end
		if (s_axi_arvalid && s_axi_arready)
		begin
			nxt_rvalid = 1'b1;
			nxt_rresp = sbc_pkg::RESP_OKAY;
			unique case (s_axi_araddr[7:0])
				sbc_pkg::OFS_CTRL: nxt_rdata = {31'h0, full_page_ff};
				sbc_pkg::OFS_STATUS: nxt_rdata = status;
				sbc_pkg::OFS_REFCNT: nxt_rdata = {20'h0, refcnt_ff};
				default:
				begin
					nxt_rdata = '0;
					nxt_rresp = sbc_pkg::RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			aw_hold_ff <= 1'b0;
			w_hold_ff <= 1'b0;
			awaddr_ff <= '0;
			wdata_ff <= '0;
			wstrb0_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff <= sbc_pkg::RESP_OKAY;
			rvalid_ff <= 1'b0;
			rresp_ff <= sbc_pkg::RESP_OKAY;
			rdata_ff <= '0;
			full_page_ff <= sbc_pkg::CTRL_FULL_PAGE_RST;
			illegal_ff <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_arready <= 1'b0;
		end
		else
		begin
			aw_hold_ff <= nxt_aw_hold;
			w_hold_ff <= nxt_w_hold;
			awaddr_ff <= nxt_awaddr;
			wdata_ff <= nxt_wdata;
			wstrb0_ff <= nxt_wstrb0;
			bvalid_ff <= nxt_bvalid;
			bresp_ff <= nxt_bresp;
			rvalid_ff <= nxt_rvalid;
			rresp_ff <= nxt_rresp;
			rdata_ff <= nxt_rdata;
			full_page_ff <= nxt_full_page;
			illegal_ff <= nxt_illegal;
			s_axi_awready <= !nxt_aw_hold;
			s_axi_wready <= !nxt_w_hold;
			s_axi_arready <= !nxt_rvalid;
		end
	end

	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rresp = rresp_ff;
	assign s_axi_rdata = rdata_ff;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_act_opens: assert property (@(posedge clk_sys) disable iff (reset)
		(is_act && !ill_act) |=> bif.open[$past(bsel)])
		else $error("active did not open bank");
	a_col_start: assert property (@(posedge clk_sys) disable iff (reset)
		((is_rd || is_wr) && !ill_rw)
		|=> col_ff == 8'($past(col_in) + 8'h01))
		else $error("burst did not start at given column");
	a_ap_closes: assert property (@(posedge clk_sys) disable iff (reset)
		(acc_last && acc_ap) |=> !bif.open[$past(acc_bank)])
		else $error("auto precharge left bank open");
	a_read_masked: assert property (@(posedge clk_sys) disable iff (reset)
		(acc_v && !acc_wr && dqm[0]) |-> ##2 (dq_oe[7:0] == 8'h00))
		else $error("masked read lane driven");
	a_read_driven: assert property (@(posedge clk_sys) disable iff (reset)
		(acc_v && !acc_wr && !dqm[0]) ##1 !is_wr |-> ##1 (dq_oe[7:0] == 8'hff))
		else $error("unmasked read lane not driven");
	a_write_store: assert property (@(posedge clk_sys) disable iff (reset)
		(acc_v && acc_wr && !dqm[0]) |=> mem_ff[$past(idx)][7:0] == $past(wr_lo))
		else $error("unmasked write lane not stored");
	a_pre_all: assert property (@(posedge clk_sys) disable iff (reset)
		(is_pre && ap_in) |=> (bif.open == 4'h0))
		else $error("precharge all left a bank open");
	a_bst_keeps: assert property (@(posedge clk_sys) disable iff (reset)
		is_bst |=> (mode_ff == sbc_pkg::MODE_IDLE) && bif.open == $past(bif.open))
		else $error("terminate did not stop burst or closed row");
	a_ref_count: assert property (@(posedge clk_sys) disable iff (reset)
		(is_ref && !ill_ref) |=> refcnt_ff == 12'($past(refcnt_ff) + 12'h001))
		else $error("refresh counter did not advance");
	a_sref_quiet: assert property (@(posedge clk_sys) disable iff (reset)
		(in_sref && !cke) |=> in_sref && !acc_v && !$changed(bif.open))
		else $error("self refresh reacted to inputs");
	a_illegal_flag: assert property (@(posedge clk_sys) disable iff (reset)
		(ill_act || ill_rw || ill_ref) |=> illegal_ff)
		else $error("illegal command not flagged");
endmodule

// ### verif/sbc_ctl_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// controller model on the command pins
// ----------------------------------------
module sbc_ctl_model (
	input wire logic clk_sys,
	output logic cke,
	output logic cs_n,
	output logic ras_n,
	output logic cas_n,
	output logic we_n,
	output logic bank_select_bit_zero,
	output logic bank_select_bit_one,
	output logic [11:0] addr,
	output logic [1:0] dqm,
	output logic [15:0] dq_in
);
	initial
	begin
		cke = 1'b1;
		{cs_n, ras_n, cas_n, we_n} = sbc_pkg::CMD_NOP;
		{bank_select_bit_one, bank_select_bit_zero} = 2'h0;
		addr = 12'h000;
		dqm = 2'h0;
		dq_in = 16'h5a5a;
	end
	// one command per edge; held until the next call, so end with a nop
	task automatic cmd(input sbc_pkg::sbc_cmd_t c, input logic [1:0] b,
		input logic [11:0] a, input logic [1:0] m, input logic [15:0] d,
		input logic dv, input logic ce);
		@(posedge clk_sys);
		cke <= ce;
		{cs_n, ras_n, cas_n, we_n} <= c;
		{bank_select_bit_one, bank_select_bit_zero} <= b;
		addr <= a;
		dqm <= m;
		// idle data bus toggles instead of holding a stale word
		dq_in <= dv ? d : ~dq_in;
	endtask
endmodule

// ### verif/sbc_top_test.sv
`timescale 1ns/1ns
`define CHK(a, e) \
	begin \
		check_count++; \
		if ((a) !== (e)) \
		begin \
			n_fail++; \
			$display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); \
		end \
	end
module sbc_top_test;
	logic clk_sys;
	logic reset;
	logic cke, cs_n, ras_n, cas_n, we_n;
	logic [1:0] bsel, dqm, bresp, rresp, resp;
	logic [11:0] addr;
	logic [15:0] dq_in, dq_out, dq_oe, m;
	logic [31:0] awaddr, wdata, araddr, rdata, v;
	logic [3:0] wstrb;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [15:0] w [4] = '{16'hb0c0, 16'ha0c1, 16'hb0c2, 16'hb0c3};
	int n_fail = 0;
	int check_count = 0;
	int i;
	sbc_top i_dut (.clk_sys(clk_sys), .reset(reset), .cke(cke), .cs_n(cs_n),
		.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
		.bank_select_bit_zero(bsel[0]), .bank_select_bit_one(bsel[1]),
		.addr(addr), .dqm(dqm), .dq_in(dq_in), .dq_out(dq_out),
		.dq_oe(dq_oe), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));
	sbc_ctl_model i_ctl (.clk_sys(clk_sys), .cke(cke), .cs_n(cs_n),
		.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
		.bank_select_bit_zero(bsel[0]), .bank_select_bit_one(bsel[1]),
		.addr(addr), .dqm(dqm), .dq_in(dq_in));
	// ----------------------------------------
	// bus tasks
	// ----------------------------------------
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic hang();
		n_fail++;
		$display("[FAIL] t=%0t got %h exp %h", $time, 1'b0, 1'b1);
		final_report();
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		awaddr <= {24'h0, a};
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 64; i++)
		begin
			@(posedge clk_sys);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		// bready stays high between writes: no double drive in one step
		resp = bresp;
		if (i == 64) hang();
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		araddr <= {24'h0, a};
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 64; i++)
		begin
			@(posedge clk_sys);
			if (arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		v = rdata;
		resp = rresp;
		if (i == 64) hang();
		`CHK(v, e)
	endtask
	task automatic op(input sbc_pkg::sbc_cmd_t c, input logic [1:0] b,
		input logic [11:0] a);
		i_ctl.cmd(c, b, a, 2'h0, 16'h0, 1'b0, 1'b1);
	endtask
	task automatic nops(input int n);
		repeat (n) op(sbc_pkg::CMD_NOP, 2'h0, 12'h000);
	endtask
	task automatic wr_burst(input logic [11:0] a, input logic [15:0] base,
		input logic [1:0] m1);
		for (int k = 0; k < 4; k++)
			i_ctl.cmd((k == 0) ? sbc_pkg::CMD_WRITE : sbc_pkg::CMD_NOP, 2'h1,
				a, (k == 1) ? m1 : 2'h0, base + 16'(k), 1'b1, 1'b1);
	endtask
	initial
	begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		reset = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, wdata, araddr, wstrb} = 100'h0;
		repeat (12) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		rd_chk(sbc_pkg::OFS_CTRL, 32'h0);
		rd_chk(sbc_pkg::OFS_STATUS, 32'h0);
		wr(sbc_pkg::OFS_REFCNT, 32'h55);
		`CHK(resp, sbc_pkg::RESP_SLVERR)
		rd_chk(sbc_pkg::OFS_REFCNT, 32'h0);
		`CHK(resp, sbc_pkg::RESP_OKAY)
		rd_chk(8'h0c, 32'h0);
		`CHK(resp, sbc_pkg::RESP_SLVERR)
		op(sbc_pkg::CMD_ACT, 2'h1, 12'h005);
		nops(3);
		rd_chk(sbc_pkg::OFS_STATUS, 32'h2);
		// high column bits must be ignored on x16
		wr_burst(12'h302, 16'ha000, 2'h0);
		wr_burst(12'h302, 16'hb0c0, 2'h2);
		op(sbc_pkg::CMD_READ, 2'h1, 12'h002);
		i_ctl.cmd(sbc_pkg::CMD_NOP, 2'h0, 12'h0, 2'h1, 16'h0, 1'b0, 1'b1);
		for (int j = 0; j < 4; j++)
		begin
			nops(1);
			#1;
			m = (j == 1) ? 16'hff00 : 16'hffff;
			`CHK(dq_oe, m)
			`CHK(dq_out & m, w[j] & m)
		end
		nops(1);
		#1;
		`CHK(dq_oe, 16'h0)
		op(sbc_pkg::CMD_PRE, 2'h1, 12'h000);
		nops(3);
		rd_chk(sbc_pkg::OFS_STATUS, 32'h0);
		op(sbc_pkg::CMD_ACT, 2'h1, 12'h007);
		nops(2);
		op(sbc_pkg::CMD_ACT, 2'h2, 12'h001);
		nops(3);
		rd_chk(sbc_pkg::OFS_STATUS, 32'h6);
		op(sbc_pkg::CMD_READ, 2'h2, 12'h000);
		op(sbc_pkg::CMD_READ, 2'h1, 12'h400);
		nops(8);
		rd_chk(sbc_pkg::OFS_STATUS, 32'h4);
		op(sbc_pkg::CMD_READ, 2'h1, 12'h000);
		nops(1);
		rd_chk(sbc_pkg::OFS_STATUS, 32'h24);
		wr(sbc_pkg::OFS_STATUS, 32'h20);
		rd_chk(sbc_pkg::OFS_STATUS, 32'h4);
		// full page: burst outlives four, stop it with terminate
		wr(sbc_pkg::OFS_CTRL, 32'h1);
		op(sbc_pkg::CMD_READ, 2'h2, 12'h400);
		nops(6);
		#1;
		`CHK(dq_oe, 16'hffff)
		op(sbc_pkg::CMD_BST, 2'h0, 12'h000);
		nops(2);
		#1;
		`CHK(dq_oe, 16'h0)
		rd_chk(sbc_pkg::OFS_STATUS, 32'h4);
		wr(sbc_pkg::OFS_CTRL, 32'h0);
		op(sbc_pkg::CMD_ACT, 2'h0, 12'h001);
		nops(3);
		rd_chk(sbc_pkg::OFS_STATUS, 32'h5);
		op(sbc_pkg::CMD_PRE, 2'h3, 12'h400);
		nops(3);
		rd_chk(sbc_pkg::OFS_STATUS, 32'h0);
		op(sbc_pkg::CMD_REF, 2'h2, 12'hfff);
		nops(8);
		rd_chk(sbc_pkg::OFS_REFCNT, 32'h1);
		op(sbc_pkg::CMD_ACT, 2'h0, 12'h000);
		nops(3);
		op(sbc_pkg::CMD_REF, 2'h0, 12'h000);
		nops(1);
		rd_chk(sbc_pkg::OFS_STATUS, 32'h21);
		rd_chk(sbc_pkg::OFS_REFCNT, 32'h1);
		wr(sbc_pkg::OFS_STATUS, 32'h20);
		op(sbc_pkg::CMD_PRE, 2'h0, 12'h000);
		nops(3);
		// self refresh; a command while inside must be ignored
		i_ctl.cmd(sbc_pkg::CMD_REF, 2'h0, 12'h0, 2'h0, 16'h0, 1'b0, 1'b0);
		i_ctl.cmd(sbc_pkg::CMD_ACT, 2'h1, 12'h3, 2'h0, 16'h0, 1'b0, 1'b0);
		i_ctl.cmd(sbc_pkg::CMD_NOP, 2'h0, 12'h0, 2'h0, 16'h0, 1'b0, 1'b0);
		repeat (100) @(posedge clk_sys);
		rd_chk(sbc_pkg::OFS_STATUS, 32'h10);
		rd_chk(sbc_pkg::OFS_REFCNT, 32'h1);
		repeat (2000) @(posedge clk_sys);
		rd_chk(sbc_pkg::OFS_REFCNT, 32'h2);
		nops(3);
		rd_chk(sbc_pkg::OFS_STATUS, 32'h0);
		// shared row counter: next refresh after exit continues from it
		op(sbc_pkg::CMD_REF, 2'h0, 12'h000);
		nops(2);
		rd_chk(sbc_pkg::OFS_REFCNT, 32'h3);
		final_report();
	end
endmodule
